/* dual_serial_dev.sv */
// Device end: 128-byte register space behind an SPI or I2C slave port
// Overview of operation
// - Strap high selects I2C, low selects SPI
// - Clock level at select fall sets order
// - SPI carries 7-bit address, 8-bit data
// - SPI logic reset while select high
// - First address bit: 1 read, 0 write
// - SPI burst increments address per byte
// - Half duplex: inputs ignored while reading
// - I2C slave only, 7-bit address, 100/400k
// - I2C bytes move most significant first
// - I2C write: slave, register, data bytes
// - I2C read: address write, then read
// - Slave address: fixed nibble plus straps
// - I2C burst increments from given address
// - I2C burst stops at top, no wrap
// - Reset low 300 ns, then defaults
`timescale 1ns/1ps
`include "dual_serial_params.svh"
module dual_serial_dev
  import dual_serial_pkg::*;
(
  input  wire logic       MCLK_I,            // System clock
  input  wire logic       RST_N_I,           // Async reset, active low
  dual_serial_if.dev      PINS,              // Serial pins
  input  wire logic       I2C_EN_I,          // Interface select strap
  input  wire logic       ADDR_STRAP1_PIN_I, // I2C address bit 1
  input  wire logic       ADDR_STRAP2_PIN_I, // I2C address bit 2
  output logic            MODE_I2C_O,        // Port is in I2C mode
  output logic            REG_WR_O,          // Register written, pulse
  output logic [6:0]      REG_ADDR_O,        // Address of that write
  output logic [7:0]      REG_DATA_O         // Data of that write
);
  logic [`SYNC_W-1:0] pin_raw, sync1_r, sync2_r, prev_r;
  logic        cs_n, sck, sda, i2c_mode;
  logic        sck_rise, sck_fall, cs_fall, start, stop;
  reg_addr_t   slave_addr;
  reg_data_t   mem_r [`REG_DEPTH];
  dev_state_e  st_r, st_nxt;
  logic [2:0]  bit_r, bit_nxt;
  logic [1:0]  byte_r, byte_nxt;
  reg_data_t   sh_r, sh_nxt, rd_byte, wr_data, wd_r;
  reg_addr_t   addr_r, addr_nxt, wr_addr, wa_r;
  logic        rw_r, rw_nxt, lsb_r, lsb_nxt, end_r, end_nxt;
  logic        sda_oe_r, sda_oe_nxt, so_r, so_nxt, so_oe_r, so_oe_nxt;
  logic        wr_en, wr_r, mode_r;

  // Every pin is foreign to MCLK, so all pass two flops first
  assign pin_raw = {ADDR_STRAP2_PIN_I, ADDR_STRAP1_PIN_I, I2C_EN_I,
                    PINS.serial_data, PINS.serial_clk, PINS.chip_select_addr0_pin};
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync1_r <= '1;
      sync2_r <= '1;
      prev_r  <= '1;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign cs_n     = sync2_r[`PIN_CS];
  assign sck      = sync2_r[`PIN_SCK];
  assign sda      = sync2_r[`PIN_SDA];
  assign i2c_mode = sync2_r[`PIN_I2C_EN];
  assign sck_rise = sck & ~prev_r[`PIN_SCK];
  assign sck_fall = ~sck & prev_r[`PIN_SCK];
  assign cs_fall  = ~cs_n & prev_r[`PIN_CS];
  assign start    = sck & prev_r[`PIN_SCK] & prev_r[`PIN_SDA] & ~sda;
  assign stop     = sck & prev_r[`PIN_SCK] & ~prev_r[`PIN_SDA] & sda;
  assign slave_addr = {`I2C_FIXED_ADDR, sync2_r[`PIN_STRAP2], sync2_r[`PIN_STRAP1], cs_n};

  genvar gi;
  generate
    for (gi = 0; gi < `REG_DEPTH; gi++) begin : g_mem
      always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          mem_r[gi] <= `REG_RESET_VAL;
        end else if (wr_en && wr_addr == 7'(gi)) begin
          mem_r[gi] <= wr_data;
        end
      end
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;  bit_nxt = bit_r;  byte_nxt = byte_r;  sh_nxt = sh_r;
    addr_nxt = addr_r;  rw_nxt = rw_r;  lsb_nxt = lsb_r;  end_nxt = end_r;
    sda_oe_nxt = sda_oe_r;  so_nxt = so_r;  so_oe_nxt = so_oe_r;
    wr_en = 1'b0;
    wr_addr = addr_r;
    wr_data = sh_r;
    rd_byte = (addr_r <= `REG_IMPL_TOP && !end_r) ? mem_r[addr_r] : `REG_RESET_VAL;
    if (!i2c_mode) begin
      sda_oe_nxt = 1'b0;
      if (cs_n) begin
        st_nxt = ST_IDLE;
        so_oe_nxt = 1'b0;
      end else if (cs_fall) begin
        st_nxt = SP_ADDR;
        lsb_nxt = sck;
        bit_nxt = 3'h0;
        end_nxt = 1'b0;
        so_oe_nxt = 1'b0;
      end else if (st_r == SP_ADDR && sck_rise) begin
        if (bit_r == 3'h0) rw_nxt = sda;
        else sh_nxt = lsb_r ? {sda, sh_r[7:1]} : {sh_r[6:0], sda};
        bit_nxt = bit_r + 3'h1;
        if (bit_r == `DEV_LAST_BIT) begin
          st_nxt = SP_DATA;
          addr_nxt = lsb_r ? sh_nxt[7:1] : sh_nxt[6:0];
        end
      end else if (st_r == SP_DATA && rw_r && sck_fall) begin
        so_oe_nxt = 1'b1;
        so_nxt = lsb_r ? rd_byte[bit_r] : rd_byte[3'h7 - bit_r];
      end else if (st_r == SP_DATA && sck_rise) begin
        // Read cycles leave the shifter alone
        if (!rw_r) sh_nxt = lsb_r ? {sda, sh_r[7:1]} : {sh_r[6:0], sda};
        bit_nxt = bit_r + 3'h1;
        if (bit_r == `DEV_LAST_BIT) begin
          wr_en = !rw_r && addr_r <= `REG_IMPL_TOP;
          wr_data = sh_nxt;
          addr_nxt = addr_r + 7'h01;
        end
      end
    end else begin
      so_oe_nxt = 1'b0;
      if (stop) begin
        st_nxt = ST_IDLE;
        sda_oe_nxt = 1'b0;
      end else if (start) begin
        st_nxt = IC_RX;
        bit_nxt = 3'h0;
        byte_nxt = 2'h0;
        sda_oe_nxt = 1'b0;
      end else begin
        case (st_r)
          ST_IDLE: ;
          IC_RX: if (sck_rise) begin
            sh_nxt = {sh_r[6:0], sda};
            bit_nxt = bit_r + 3'h1;
            if (bit_r == `DEV_LAST_BIT) st_nxt = IC_RXACK;
          end
          IC_RXACK: if (sck_fall) begin
            sda_oe_nxt = 1'b1;
            st_nxt = IC_ACK;
            if (byte_r == 2'h0) begin
              rw_nxt = sh_r[0];
              if (sh_r[7:1] != slave_addr) begin
                st_nxt = ST_IDLE;
                sda_oe_nxt = 1'b0;
              end
            end else if (byte_r == 2'h1) begin
              addr_nxt = sh_r[6:0];
              end_nxt = 1'b0;
            end else if (!end_r) begin
              wr_en = addr_r <= `REG_IMPL_TOP;
              if (addr_r == `REG_ADDR_MAX) end_nxt = 1'b1;
              else addr_nxt = addr_r + 7'h01;
            end
            if (byte_r != 2'h2) byte_nxt = byte_r + 2'h1;
          end
          IC_ACK: if (sck_fall) begin
            bit_nxt = 3'h0;
            if (rw_r) begin
              st_nxt = IC_TX;
              sda_oe_nxt = ~rd_byte[7];
            end else begin
              st_nxt = IC_RX;
              sda_oe_nxt = 1'b0;
            end
          end
          IC_TX: if (sck_fall) begin
            if (bit_r == `DEV_LAST_BIT) begin
              sda_oe_nxt = 1'b0;
              st_nxt = IC_TXACK;
            end else begin
              bit_nxt = bit_r + 3'h1;
              sda_oe_nxt = ~rd_byte[3'h6 - bit_r];
            end
          end
          IC_TXACK: if (sck_rise) begin
            if (sda) st_nxt = ST_IDLE;
            else if (addr_r == `REG_ADDR_MAX) end_nxt = 1'b1;
            else addr_nxt = addr_r + 7'h01;
          end else if (sck_fall) begin
            bit_nxt = 3'h0;
            st_nxt = IC_TX;
            sda_oe_nxt = ~rd_byte[7];
          end
          default: st_nxt = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r <= ST_IDLE;  bit_r <= 3'h0;  byte_r <= 2'h0;  sh_r <= 8'h00;
      addr_r <= 7'h00;  rw_r <= 1'b0;  lsb_r <= 1'b0;  end_r <= 1'b0;
      sda_oe_r <= 1'b0;  so_r <= 1'b0;  so_oe_r <= 1'b0;
      wr_r <= 1'b0;  wa_r <= 7'h00;  wd_r <= 8'h00;  mode_r <= 1'b0;
    end else begin
      st_r <= st_nxt;  bit_r <= bit_nxt;  byte_r <= byte_nxt;  sh_r <= sh_nxt;
      addr_r <= addr_nxt;  rw_r <= rw_nxt;  lsb_r <= lsb_nxt;  end_r <= end_nxt;
      sda_oe_r <= sda_oe_nxt;  so_r <= so_nxt;  so_oe_r <= so_oe_nxt;
      wr_r <= wr_en;  wa_r <= wr_addr;  wd_r <= wr_data;  mode_r <= i2c_mode;
    end
  end

  assign PINS.dev_data_o  = 1'b0;
  assign PINS.dev_data_oe = sda_oe_r;
  assign PINS.dev_out_o   = so_r;
  assign PINS.dev_out_oe  = so_oe_r;
  assign MODE_I2C_O = mode_r;
  assign REG_WR_O   = wr_r;
  assign REG_ADDR_O = wa_r;
  assign REG_DATA_O = wd_r;
endmodule

/* dual_serial_params.svh */
// Constants of the dual SPI / I2C host configuration port
`ifndef DUAL_SERIAL_PARAMS_SVH
`define DUAL_SERIAL_PARAMS_SVH
`define MCLK_PERIOD_NS  100
`define RST_MIN_NS      300
`define RST_MIN_CYC     ((`RST_MIN_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define I2C_STD_KBPS    100
`define I2C_FAST_KBPS   400
`define HOST_Q_DIV      (4 * `I2C_FAST_KBPS * `MCLK_PERIOD_NS)
`define HOST_Q_CYC      ((1000000 + `HOST_Q_DIV - 1) / `HOST_Q_DIV)
`define REG_DEPTH       128
`define REG_ADDR_MAX    7'h7F
`define REG_IMPL_TOP    7'h77
`define REG_RESET_VAL   8'h00
`define I2C_FIXED_ADDR  4'hA
`define DEV_LAST_BIT    3'h7
`define HOST_LAST_I2C   4'h8
`define HOST_LAST_SPI   4'h7
`define SYNC_W          6
`define PIN_CS          0
`define PIN_SCK         1
`define PIN_SDA         2
`define PIN_I2C_EN      3
`define PIN_STRAP1      4
`define PIN_STRAP2      5
`endif

/* dual_serial_pkg.sv */
// Types shared by both ends of the dual serial port
package dual_serial_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    SP_ADDR  = 3'b001,
    SP_DATA  = 3'b010,
    IC_RX    = 3'b011,
    IC_RXACK = 3'b100,
    IC_ACK   = 3'b101,
    IC_TX    = 3'b110,
    IC_TXACK = 3'b111
  } dev_state_e;
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_START = 3'b001,
    H_BIT   = 3'b010,
    H_STOP  = 3'b011,
    H_DONE  = 3'b100
  } host_state_e;
  typedef logic [6:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
endpackage

/* dual_serial_if.sv */
// Pins between the host processor and the configuration port
`timescale 1ns/1ps
interface dual_serial_if;
  logic serial_clk;            // SPI clock / I2C clock, host driven
  logic chip_select_addr0_pin; // SPI select (low) / I2C address strap
  logic host_data_o;           // Host data level
  logic host_data_oe;          // Host drives data pin
  logic dev_data_o;            // Device data level (always low)
  logic dev_data_oe;           // Device pulls data pin low
  logic serial_data;           // Resolved data pin, pulled up
  logic dev_out_o;             // SPI serial out level
  logic dev_out_oe;            // SPI serial out driven
  logic serial_out;            // Resolved serial out

  // Wired-AND with pull-up; a push-pull host high is seen as released
  assign serial_data = ~((host_data_oe & ~host_data_o) | (dev_data_oe & ~dev_data_o));
  assign serial_out  = dev_out_oe & dev_out_o;

  modport host (output serial_clk, chip_select_addr0_pin, host_data_o, host_data_oe,
                input  serial_data, serial_out);
  modport dev  (input  serial_clk, chip_select_addr0_pin, serial_data,
                output dev_data_o, dev_data_oe, dev_out_o, dev_out_oe);
endinterface

/* dual_serial_host.sv */
// Host processor end: SPI or I2C master issuing single register accesses
`timescale 1ns/1ps
`include "dual_serial_params.svh"
module dual_serial_host
  import dual_serial_pkg::*;
(
  input  wire logic       MCLK_I,          // System clock
  input  wire logic       RST_N_I,         // Async reset, active low
  dual_serial_if.host     PINS,            // Serial pins
  input  wire logic       CMD_VALID_I,     // Start an access
  input  wire logic       CMD_READ_I,      // 1 read, 0 write
  input  wire logic       CMD_I2C_I,       // 1 I2C, 0 SPI
  input  wire logic       CMD_LSB_FIRST_I, // SPI bit order
  input  wire logic [6:0] CMD_DEV_ADDR_I,  // I2C slave address
  input  wire logic [6:0] CMD_ADDR_I,      // Register address
  input  wire logic [7:0] CMD_WDATA_I,     // Write data
  output logic            BUSY_O,          // Access in progress
  output logic            DONE_O,          // Access finished, pulse
  output logic [7:0]      RDATA_O,         // Read data
  output logic            NACK_O           // I2C slave did not ack
);
  logic [1:0]  sync1_r, sync2_r;
  host_state_e st_r, st_nxt;
  logic [1:0]  q_r, q_nxt, idx_r, idx_nxt, last_idx;
  logic [2:0]  cnt_r, cnt_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic        ph_r, ph_nxt, rd_r, rd_nxt, i2c_r, i2c_nxt, lsb_r, lsb_nxt;
  reg_addr_t   dev_r, dev_nxt, addr_r, addr_nxt;
  reg_data_t   wd_r, wd_nxt, rx_r, rx_nxt, rdata_r, rdata_nxt, tx_byte;
  logic        scl_r, scl_nxt, cs_r, cs_nxt, dout_r, dout_nxt, doe_r, doe_nxt;
  logic        busy_r, busy_nxt, done_r, done_nxt, nack_r, nack_nxt;
  logic        tick, is_rx, tx_bit, sda_s, so_s;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync1_r <= 2'h3;
      sync2_r <= 2'h3;
    end else begin
      sync1_r <= {PINS.serial_out, PINS.serial_data};
      sync2_r <= sync1_r;
    end
  end
  assign sda_s = sync2_r[0];
  assign so_s  = sync2_r[1];
  assign tick  = (cnt_r == 3'(`HOST_Q_CYC - 1));

  always_comb begin
    if (i2c_r) begin
      tx_byte = (idx_r == 2'h0) ? {dev_r, ph_r} : (idx_r == 2'h1) ? {1'b0, addr_r} : wd_r;
    end else if (idx_r == 2'h0) begin
      tx_byte = lsb_r ? {addr_r, rd_r} : {rd_r, addr_r};
    end else begin
      tx_byte = wd_r;
    end
    tx_bit   = (lsb_r && !i2c_r) ? tx_byte[bit_r[2:0]] : tx_byte[3'h7 - bit_r[2:0]];
    is_rx    = (idx_r == 2'h1) && (i2c_r ? ph_r : rd_r);
    last_idx = (i2c_r && !ph_r && !rd_r) ? 2'h2 : 2'h1;
  end

  always_comb begin
    st_nxt = st_r;  q_nxt = q_r;  idx_nxt = idx_r;  bit_nxt = bit_r;
    ph_nxt = ph_r;  rd_nxt = rd_r;  i2c_nxt = i2c_r;  lsb_nxt = lsb_r;
    dev_nxt = dev_r;  addr_nxt = addr_r;  wd_nxt = wd_r;  rx_nxt = rx_r;
    scl_nxt = scl_r;  cs_nxt = cs_r;  dout_nxt = dout_r;  doe_nxt = doe_r;
    busy_nxt = busy_r;  nack_nxt = nack_r;  rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    cnt_nxt  = (st_r == H_IDLE || tick) ? 3'h0 : cnt_r + 3'h1;
    if (tick) q_nxt = q_r + 2'h1;
    case (st_r)
      H_IDLE: begin
        q_nxt = 2'h0;
        if (CMD_VALID_I) begin
          rd_nxt = CMD_READ_I;  i2c_nxt = CMD_I2C_I;  lsb_nxt = CMD_LSB_FIRST_I;
          dev_nxt = CMD_DEV_ADDR_I;  addr_nxt = CMD_ADDR_I;  wd_nxt = CMD_WDATA_I;
          ph_nxt = 1'b0;  nack_nxt = 1'b0;  busy_nxt = 1'b1;  st_nxt = H_START;
        end
      end
      H_START: if (tick) begin
        case (q_r)
          2'h0: if (i2c_r) begin scl_nxt = 1'b1; doe_nxt = 1'b0; end
                else scl_nxt = lsb_r;
          2'h1: if (i2c_r) begin doe_nxt = 1'b1; dout_nxt = 1'b0; end
                else cs_nxt = 1'b0;
          2'h2: scl_nxt = 1'b0;
          default: begin st_nxt = H_BIT; bit_nxt = 4'h0; idx_nxt = 2'h0; end
        endcase
      end
      H_BIT: if (tick) begin
        case (q_r)
          2'h0: begin
            scl_nxt = 1'b0;
            if (i2c_r) begin
              dout_nxt = 1'b0;
              doe_nxt  = !is_rx && bit_r != `HOST_LAST_I2C && !tx_bit;
            end else begin
              doe_nxt  = 1'b1;
              dout_nxt = tx_bit;
            end
          end
          2'h1: scl_nxt = 1'b1;
          2'h2: if (i2c_r) begin
            if (bit_r != `HOST_LAST_I2C) rx_nxt = {rx_r[6:0], sda_s};
            else if (!is_rx && sda_s) nack_nxt = 1'b1;
          end else if (is_rx) begin
            rx_nxt = lsb_r ? {so_s, rx_r[7:1]} : {rx_r[6:0], so_s};
          end
          default: begin
            scl_nxt = 1'b0;
            if (bit_r == (i2c_r ? `HOST_LAST_I2C : `HOST_LAST_SPI)) begin
              bit_nxt = 4'h0;
              if (nack_r || idx_r == last_idx) st_nxt = i2c_r ? H_STOP : H_DONE;
              else idx_nxt = idx_r + 2'h1;
            end else begin
              bit_nxt = bit_r + 4'h1;
            end
          end
        endcase
      end
      H_STOP: if (tick) begin
        case (q_r)
          2'h0: begin scl_nxt = 1'b0; doe_nxt = 1'b1; dout_nxt = 1'b0; end
          2'h1: scl_nxt = 1'b1;
          2'h2: doe_nxt = 1'b0;
          default: if (!ph_r && rd_r && !nack_r) begin
            ph_nxt = 1'b1;
            st_nxt = H_START;
          end else begin
            st_nxt = H_DONE;
          end
        endcase
      end
      H_DONE: if (tick) begin
        if (q_r == 2'h0) begin
          cs_nxt  = 1'b1;
          doe_nxt = 1'b0;
          scl_nxt = 1'b1;
        end
        if (q_r == 2'h3) begin
          st_nxt = H_IDLE;  busy_nxt = 1'b0;  done_nxt = 1'b1;  rdata_nxt = rx_r;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r <= H_IDLE;  q_r <= 2'h0;  idx_r <= 2'h0;  bit_r <= 4'h0;  cnt_r <= 3'h0;
      ph_r <= 1'b0;  rd_r <= 1'b0;  i2c_r <= 1'b0;  lsb_r <= 1'b0;
      dev_r <= 7'h00;  addr_r <= 7'h00;  wd_r <= 8'h00;  rx_r <= 8'h00;  rdata_r <= 8'h00;
      scl_r <= 1'b1;  cs_r <= 1'b1;  dout_r <= 1'b1;  doe_r <= 1'b0;
      busy_r <= 1'b0;  done_r <= 1'b0;  nack_r <= 1'b0;
    end else begin
      st_r <= st_nxt;  q_r <= q_nxt;  idx_r <= idx_nxt;  bit_r <= bit_nxt;  cnt_r <= cnt_nxt;
      ph_r <= ph_nxt;  rd_r <= rd_nxt;  i2c_r <= i2c_nxt;  lsb_r <= lsb_nxt;
      dev_r <= dev_nxt;  addr_r <= addr_nxt;  wd_r <= wd_nxt;  rx_r <= rx_nxt;
      rdata_r <= rdata_nxt;
      scl_r <= scl_nxt;  cs_r <= cs_nxt;  dout_r <= dout_nxt;  doe_r <= doe_nxt;
      busy_r <= busy_nxt;  done_r <= done_nxt;  nack_r <= nack_nxt;
    end
  end

  assign PINS.serial_clk            = scl_r;
  assign PINS.chip_select_addr0_pin = cs_r;
  assign PINS.host_data_o           = dout_r;
  assign PINS.host_data_oe          = doe_r;
  assign BUSY_O  = busy_r;
  assign DONE_O  = done_r;
  assign RDATA_O = rdata_r;
  assign NACK_O  = nack_r;
endmodule

/* dual_serial_props.sv */
// Concurrent checks on the serial pins between the host and device ends
`timescale 1ns/1ps
module dual_serial_props (
  input  wire logic MCLK_I,                // System clock
  input  wire logic RST_N_I,               // Async reset, active low
  input  wire logic serial_clk,            // Host serial clock
  input  wire logic chip_select_addr0_pin, // SPI select / I2C strap
  input  wire logic dev_data_o,            // Device data level
  input  wire logic dev_data_oe,           // Device pulls data low
  input  wire logic dev_out_o,             // SPI serial out level
  input  wire logic dev_out_oe             // SPI serial out driven
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // Device moves its outputs a few cycles after a clock falling edge, and releases serial out after a deselect
  sequence s_sck_high;
    serial_clk [*4];
  endsequence
  sequence s_cs_idle;
    chip_select_addr0_pin [*8];
  endsequence
  // Release allows for the select synchroniser delay
  sequence s_release;
    ##[1:6] !dev_out_oe;
  endsequence

  // Pull moves only while the clock is low, so it never fakes a START or STOP
  a_od_low: assert property ($changed(dev_data_oe) |-> !serial_clk && !dev_data_o)
    else $error("device moved the data line with the clock high");
  a_so_stable: assert property (s_sck_high ##0 dev_out_oe |-> $stable(dev_out_o))
    else $error("serial out changed while the clock was high");
  a_sda_stable: assert property (serial_clk && $past(serial_clk) |-> $stable(dev_data_oe))
    else $error("device moved the data line while the clock was high");
  a_so_start: assert property ($rose(dev_out_oe) |-> !chip_select_addr0_pin && !serial_clk)
    else $error("serial out driven outside a selected clock-low phase");
  a_spi_no_sda: assert property (!chip_select_addr0_pin |-> !dev_data_oe)
    else $error("data line pulled during an SPI access");
  a_cs_release: assert property ($rose(chip_select_addr0_pin) |-> s_release)
    else $error("serial out still driven after deselect");
  a_idle_undriven: assert property (s_cs_idle |-> !dev_out_oe)
    else $error("serial out driven while deselected");
  a_ack_hold: assert property ($rose(dev_data_oe) |=> dev_data_oe [*8])
    else $error("data line pull released too early");
endmodule

/* tb.sv */
// Self-checking bench joining the host and device ends over the serial pins
`timescale 1ns/1ps
`include "dual_serial_params.svh"
module tb
  import dual_serial_pkg::*;
  ;
  logic        mclk;
  logic        rst_n;
  logic        cmd_valid;
  logic        cmd_read;
  logic        cmd_i2c;
  logic        cmd_lsb;
  logic        i2c_en;
  logic        strap1;
  logic        strap2;
  logic        busy;
  logic        done;
  logic        nack;
  logic        mode_i2c;
  logic        reg_wr;
  reg_addr_t   cmd_dev;
  reg_addr_t   cmd_addr;
  reg_addr_t   reg_addr;
  reg_addr_t   ad;
  reg_addr_t   dv;
  reg_data_t   cmd_wdata;
  reg_data_t   rdata;
  reg_data_t   reg_data;
  reg_data_t   wd;
  int          error_cnt;
  int          n_compared;
  int          cyc;
  int          seed;
  logic [9:0]  done_q[$];
  logic [14:0] wr_q[$];
  logic [9:0]  d_note;
  logic [14:0] w_note;

  dual_serial_if pins ();

  dual_serial_host dual_serial_host_inst (.MCLK_I(mclk), .RST_N_I(rst_n), .PINS(pins),
    .CMD_VALID_I(cmd_valid), .CMD_READ_I(cmd_read), .CMD_I2C_I(cmd_i2c),
    .CMD_LSB_FIRST_I(cmd_lsb), .CMD_DEV_ADDR_I(cmd_dev), .CMD_ADDR_I(cmd_addr),
    .CMD_WDATA_I(cmd_wdata), .BUSY_O(busy), .DONE_O(done), .RDATA_O(rdata), .NACK_O(nack));
  dual_serial_dev dual_serial_dev_inst (.MCLK_I(mclk), .RST_N_I(rst_n), .PINS(pins),
    .I2C_EN_I(i2c_en), .ADDR_STRAP1_PIN_I(strap1), .ADDR_STRAP2_PIN_I(strap2),
    .MODE_I2C_O(mode_i2c), .REG_WR_O(reg_wr), .REG_ADDR_O(reg_addr), .REG_DATA_O(reg_data));
  dual_serial_props dual_serial_props_inst (.MCLK_I(mclk), .RST_N_I(rst_n),
    .serial_clk(pins.serial_clk), .chip_select_addr0_pin(pins.chip_select_addr0_pin),
    .dev_data_o(pins.dev_data_o), .dev_data_oe(pins.dev_data_oe),
    .dev_out_o(pins.dev_out_o), .dev_out_oe(pins.dev_out_oe));

  always #50 mclk = ~mclk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Compared %0d, mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic apply_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask

  // Notes the outcome first, so the monitor never sees a result unannounced
  task automatic access(input logic rd, input reg_addr_t a, input reg_data_t w,
                        input logic wr_ok, input reg_data_t rexp, input logic nk);
    if (wr_ok) wr_q.push_back({a, w});
    done_q.push_back({rd, nk, rexp});
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_addr  <= a;
    cmd_wdata <= w;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    @(posedge mclk);
    check(16'(busy), 16'h0001);
    do @(posedge mclk); while (done !== 1'b1);
    @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    if (done === 1'b1) begin
      if (done_q.size() == 0) begin
        check(16'h0000, 16'h0001);
      end else begin
        d_note = done_q.pop_front();
        check(16'(busy), 16'h0000);
        check(16'(nack), 16'(d_note[8]));
        if (d_note[9]) check(16'(rdata), 16'(d_note[7:0]));
      end
    end
    if (reg_wr === 1'b1) begin
      if (wr_q.size() == 0) begin
        check(16'(reg_addr), 16'h00FF);
      end else begin
        w_note = wr_q.pop_front();
        check(16'({reg_addr, reg_data}), 16'(w_note));
      end
    end
  end

  // Ceiling well above the roughly 14k cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    mclk       = 1'b0;
    rst_n      = 1'b0;
    cmd_valid  = 1'b0;
    cmd_read   = 1'b0;
    cmd_i2c    = 1'b0;
    cmd_lsb    = 1'b0;
    cmd_dev    = 7'h00;
    cmd_addr   = 7'h00;
    cmd_wdata  = 8'h00;
    i2c_en     = 1'b0;
    strap1     = 1'b0;
    strap2     = 1'b0;
    error_cnt  = 0;
    n_compared = 0;
    cyc        = 0;
    seed       = 46;
    apply_reset();
    // Modes: SPI msb-first, SPI lsb-first, then I2C twice with new straps
    for (int m = 0; m < 4; m++) begin
      i2c_en  <= m[1];
      strap1  <= 1'($random(seed));
      strap2  <= 1'($random(seed));
      cmd_i2c <= m[1];
      cmd_lsb <= m[0];
      repeat (8) @(posedge mclk);
      check(16'(mode_i2c), 16'(m[1]));
      dv = {`I2C_FIXED_ADDR, strap2, strap1, 1'b1};
      cmd_dev <= dv;
      ad = 7'({$random(seed)} % 120);
      wd = 8'($random(seed));
      if (m[1]) access(1'b0, ad, wd, 1'b1, 8'h00, 1'b0);
      else access(1'b0, ad, wd, 1'b1, 8'h00, 1'b0);
      access(1'b1, ad, 8'h00, 1'b0, wd, 1'b0);
      access(1'b0, 7'h7A, wd, 1'b0, 8'h00, 1'b0);
      access(1'b1, 7'h7A, 8'h00, 1'b0, 8'h00, 1'b0);
    end
    // Both strap bits flipped: the device must not answer
    cmd_dev <= dv ^ 7'h06;
    access(1'b0, ad, wd, 1'b0, 8'h00, 1'b1);
    cmd_dev <= dv;
    apply_reset();
    access(1'b1, ad, 8'h00, 1'b0, 8'h00, 1'b0);
    check(16'(wr_q.size() + done_q.size()), 16'h0000);
    give_verdict();
  end
endmodule
